/* dma_arb_map.svh */
// Register offsets, control field positions, reset values and bus codes
// for the multichannel transfer engine; definitions only.
`ifndef DMA_ARB_MAP_SVH
`define DMA_ARB_MAP_SVH

// Per-channel words: byte address = channel * 16 + word offset * 4
`define CH_AREA_END 12'h200
`define OFF_SRC 2'h0
`define OFF_TGT 2'h1
`define OFF_PCTL 2'h2
`define OFF_SCTL 2'h3
// Global words
`define OFF_RUN 12'h200
`define OFF_HALT 12'h204
`define OFF_TFR 12'h208
`define OFF_ERR 12'h20C

// Primary control fields
`define F_LEN_HI 12
`define F_LEN_LO 0
`define F_TYPE_HI 14
`define F_TYPE_LO 13
`define F_SIZE_HI 16
`define F_SIZE_LO 15
`define F_BURST_HI 18
`define F_BURST_LO 17
`define F_INC_SRC 19
`define F_INC_TGT 20
// Secondary control: peripheral number
`define F_PER_HI 5
`define F_PER_LO 0

`define RST_WORD 32'h0000_0000

// Bus master codes
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HBURST_SINGLE 3'h0
`define HPROT_DATA 4'h3
`define HRESP_OKAY 1'b0

// Acknowledge falls this many cycles after the request falls
`define ACK_RELEASE_CYC 1

`endif

/* dma_arb_pkg.sv */
// Types shared by the transfer engine and its users.
// Assumes dma_arb_map.svh holds the numeric constants.
package dma_arb_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RADDR = 3'h1,
        ST_RDATA = 3'h3,
        ST_WADDR = 3'h2,
        ST_WDATA = 3'h6,
        ST_ACK = 3'h7
    } eng_state_t;

    typedef enum logic [1:0] {
        XT_MEM2MEM = 2'h0,
        XT_MEM2PER = 2'h1,
        XT_PER2MEM = 2'h2
    } xfer_type_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic [2:0] hsize;
        logic [2:0] hburst;
        logic [3:0] hprot;
        logic hmastlock;
        logic hwrite;
        logic [31:0] hwdata;
    } ahb_mst_t;

endpackage

/* dma_arb_core.sv */
// 32-channel transfer engine with weighted set arbitration.
// Assumes a synchronous register port and a single-master bus.
// What this block does
// - 32 channels, four 32-bit words each
// - Serve in bursts at programmed item width
// - One burst, then re-arbitrate among ready channels
// - Pick by run, peripheral request, set
// - Four sets of eight, round-robin inside
// - Set membership by channel number bits
// - Weighted slot order 0,1,0,2,0,1,0,3
// - Writing one to run bit starts channel
// - Run bit self-clears when block completes
// - Pending interrupt blocks a run write
// - Halt now if idle, else after burst
// - Halt request clears once run clears
// - Writing zero halt does nothing
// - Three transfer types from control field
// - Engine alone ends block by length
// - 64 peripheral handshake ports
// - Combined and per-channel interrupt outputs
// - Bus clock, asynchronous active-low reset
// - Moves data as bus master
// - Programmed through register slave port
// - Last indicator input never sampled
// - Acknowledge held until request falls, +1
// - Single request only in tail region
// - Writing one clears pending interrupt
`timescale 1ns/10ps
`include "dma_arb_map.svh"

module dma_arb_core #(
    parameter int NUM_PER = 64
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire dma_arb_pkg::reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    output dma_arb_pkg::ahb_mst_t mas_o,
    input wire logic [31:0] mas_hrdata_i,
    input wire logic mas_hready_i,
    input wire logic mas_hresp_i,
    input wire logic [NUM_PER-1:0] per_burst_req_i,
    input wire logic [NUM_PER-1:0] per_single_req_i,
    input wire logic [NUM_PER-1:0] per_last_i,
    output logic [NUM_PER-1:0] per_ack_o,
    output logic [NUM_PER-1:0] per_done_o,
    output logic intr_any_o,
    output logic [31:0] intr_chan_o
);
    import dma_arb_pkg::*;

    localparam int NCH = 32;

    logic [31:0] src_mem [NCH];
    logic [31:0] tgt_mem [NCH];
    logic [31:0] pctl_mem [NCH];
    logic [31:0] sctl_mem [NCH];

    logic [31:0] run_reg, run_next, halt_reg, halt_next;
    logic [31:0] tfr_reg, tfr_next, err_reg, err_next;
    logic [31:0] rdata_reg, rdata_next;
    logic intr_reg, intr_next;
    logic [31:0] ivec_reg, ivec_next;

    eng_state_t state_reg, state_next;
    logic [4:0] cur_ch_reg, cur_ch_next;
    logic [31:0] cur_src_reg, cur_src_next, cur_tgt_reg, cur_tgt_next;
    logic [12:0] cur_len_reg, cur_len_next;
    logic [4:0] items_reg, items_next;
    logic [31:0] data_reg, data_next;
    logic single_reg, single_next;
    ahb_mst_t mas_reg, mas_next;
    logic [NUM_PER-1:0] ack_reg, ack_next, done_reg, done_next;
    logic [2:0] slot_reg, slot_next;
    logic [2:0] rr_reg [4];
    logic [2:0] rr_next [4];

    logic wb_en, wb_blk, wb_err, wb_halt;
    logic [31:0] elig, busy_mask;
    logic [3:0] set_elig;
    logic found;
    logic [1:0] pick_set;
    logic [2:0] pick_k, pick_slot;
    logic [4:0] pick_ch;
    logic [31:0] cur_pctl;
    logic [5:0] cur_pn;
    logic cur_is_per, hs_cur;
    logic [2:0] sz_bytes;

    function automatic logic [4:0] burst_items(input logic [1:0] code);
        unique case (code)
            2'h1: burst_items = 5'h08;
            2'h2: burst_items = 5'h10;
            default: burst_items = 5'h04;
        endcase
    endfunction

    function automatic logic [6:0] txn_bytes(input logic [31:0] pc);
        txn_bytes = 7'({2'h0, burst_items(pc[`F_BURST_HI:`F_BURST_LO])}
            << pc[`F_SIZE_HI:`F_SIZE_LO]);
    endfunction

    function automatic logic [1:0] slot_set(input logic [2:0] sl);
        if (!sl[0])
            slot_set = 2'h0;
        else if (!sl[1])
            slot_set = 2'h1;
        else
            slot_set = sl[2] ? 2'h3 : 2'h2;
    endfunction

    function automatic logic [4:0] member(input logic [1:0] s, input logic [2:0] k);
        member = {k[2], s, k[1:0]};
    endfunction

    assign cur_pctl = pctl_mem[cur_ch_reg];
    assign cur_pn = sctl_mem[cur_ch_reg][`F_PER_HI:`F_PER_LO];
    assign cur_is_per = cur_pctl[`F_TYPE_HI:`F_TYPE_LO] != XT_MEM2MEM;
    assign hs_cur = single_reg ? per_single_req_i[cur_pn] : per_burst_req_i[cur_pn];
    assign sz_bytes = 3'(3'h1 << cur_pctl[`F_SIZE_HI:`F_SIZE_LO]);
    assign busy_mask = (state_reg != ST_IDLE) ? (32'h0000_0001 << cur_ch_reg) : 32'h0000_0000;

    always_comb
    begin
        logic [31:0] pc;
        logic [5:0] pn;
        logic tail, hs;
        pc = '0;
        pn = '0;
        tail = 1'b0;
        hs = 1'b0;
        for (int c = 0; c < NCH; c++)
        begin
            pc = pctl_mem[c];
            pn = sctl_mem[c][`F_PER_HI:`F_PER_LO];
            tail = {6'h00, txn_bytes(pc)} > pc[`F_LEN_HI:`F_LEN_LO];
            hs = tail ? per_single_req_i[pn] : per_burst_req_i[pn];
            elig[c] = run_reg[c] & ~halt_reg[c] & ~busy_mask[c]
                & (pc[`F_TYPE_HI:`F_TYPE_LO] == XT_MEM2MEM || hs);
        end
        for (int s = 0; s < 4; s++)
        begin
            set_elig[s] = 1'b0;
            for (int k = 0; k < 8; k++)
                set_elig[s] = set_elig[s] | elig[member(2'(s), 3'(k))];
        end
    end

    always_comb
    begin
        logic [2:0] sl;
        logic [2:0] k;
        logic got;
        sl = '0;
        k = '0;
        got = 1'b0;
        found = 1'b0;
        pick_set = 2'h0;
        pick_slot = slot_reg;
        pick_k = 3'h0;
        for (int o = 0; o < 8; o++)
        begin
            sl = 3'(slot_reg + 3'(o));
            if (!found && set_elig[slot_set(sl)])
            begin
                found = 1'b1;
                pick_set = slot_set(sl);
                pick_slot = sl;
            end
        end
        for (int o = 1; o <= 8; o++)
        begin
            k = 3'(rr_reg[pick_set] + 3'(o));
            if (!got && elig[member(pick_set, k)])
            begin
                got = 1'b1;
                pick_k = k;
            end
        end
        pick_ch = member(pick_set, pick_k);
    end

    // Transfer engine
    always_comb
    begin
        logic [31:0] pc;
        logic [12:0] len_dec;
        pc = pctl_mem[pick_ch];
        len_dec = (cur_len_reg > {10'h000, sz_bytes}) ? 13'(cur_len_reg - {10'h000, sz_bytes})
            : 13'h0000;
        state_next = state_reg;
        cur_ch_next = cur_ch_reg;
        cur_src_next = cur_src_reg;
        cur_tgt_next = cur_tgt_reg;
        cur_len_next = cur_len_reg;
        items_next = items_reg;
        data_next = data_reg;
        single_next = single_reg;
        mas_next = mas_reg;
        ack_next = ack_reg;
        done_next = done_reg;
        slot_next = slot_reg;
        rr_next = rr_reg;
        wb_en = 1'b0;
        wb_blk = 1'b0;
        wb_err = 1'b0;
        wb_halt = halt_reg[cur_ch_reg];
        unique case (state_reg)
            ST_IDLE:
            begin
                if (found)
                begin
                    cur_ch_next = pick_ch;
                    slot_next = 3'(pick_slot + 3'h1);
                    rr_next[pick_set] = pick_k;
                    cur_src_next = src_mem[pick_ch];
                    cur_tgt_next = tgt_mem[pick_ch];
                    cur_len_next = pc[`F_LEN_HI:`F_LEN_LO];
                    single_next = {6'h00, txn_bytes(pc)} > pc[`F_LEN_HI:`F_LEN_LO];
                    items_next = single_next ? 5'h01 : burst_items(pc[`F_BURST_HI:`F_BURST_LO]);
                    mas_next.haddr = src_mem[pick_ch];
                    mas_next.htrans = `HTRANS_NONSEQ;
                    mas_next.hwrite = 1'b0;
                    mas_next.hsize = {1'b0, pc[`F_SIZE_HI:`F_SIZE_LO]};
                    state_next = ST_RADDR;
                end
            end
            ST_RADDR:
            begin
                if (mas_hready_i)
                begin
                    mas_next.htrans = `HTRANS_IDLE;
                    state_next = ST_RDATA;
                end
            end
            ST_RDATA:
            begin
                if (mas_hready_i)
                begin
                    data_next = mas_hrdata_i;
                    if (mas_hresp_i != `HRESP_OKAY)
                    begin
                        wb_en = 1'b1;
                        wb_err = 1'b1;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        mas_next.haddr = cur_tgt_reg;
                        mas_next.htrans = `HTRANS_NONSEQ;
                        mas_next.hwrite = 1'b1;
                        state_next = ST_WADDR;
                    end
                end
            end
            ST_WADDR:
            begin
                if (mas_hready_i)
                begin
                    mas_next.htrans = `HTRANS_IDLE;
                    mas_next.hwdata = data_reg;
                    state_next = ST_WDATA;
                end
            end
            ST_WDATA:
            begin
                if (mas_hready_i)
                begin
                    if (cur_pctl[`F_INC_SRC])
                        cur_src_next = cur_src_reg + {29'h0, sz_bytes};
                    if (cur_pctl[`F_INC_TGT])
                        cur_tgt_next = cur_tgt_reg + {29'h0, sz_bytes};
                    cur_len_next = len_dec;
                    items_next = 5'(items_reg - 5'h01);
                    if (mas_hresp_i != `HRESP_OKAY)
                    begin
                        wb_en = 1'b1;
                        wb_err = 1'b1;
                        state_next = ST_IDLE;
                    end
                    else if (items_next == 5'h00 || len_dec == 13'h0000)
                    begin
                        wb_en = 1'b1;
                        wb_blk = len_dec == 13'h0000;
                        if (cur_is_per)
                        begin
                            ack_next[cur_pn] = 1'b1;
                            done_next[cur_pn] = wb_blk;
                            state_next = ST_ACK;
                        end
                        else
                            state_next = ST_IDLE;
                    end
                    else
                    begin
                        mas_next.haddr = cur_src_next;
                        mas_next.htrans = `HTRANS_NONSEQ;
                        mas_next.hwrite = 1'b0;
                        state_next = ST_RADDR;
                    end
                end
            end
            ST_ACK:
            begin
                if (!hs_cur)
                begin
                    ack_next[cur_pn] = 1'b0;
                    done_next[cur_pn] = 1'b0;
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // Run, halt, status and read data
    always_comb
    begin
        logic [31:0] clr;
        clr = '0;
        run_next = run_reg;
        halt_next = halt_reg;
        tfr_next = tfr_reg;
        err_next = err_reg;
        rdata_next = 32'h0000_0000;
        if (reg_req_i.wr)
        begin
            unique case (reg_req_i.addr)
                `OFF_RUN: run_next = run_reg | (reg_req_i.wdata & ~(tfr_reg | err_reg));
                `OFF_HALT: halt_next = halt_reg | reg_req_i.wdata;
                `OFF_TFR: tfr_next = tfr_reg & ~reg_req_i.wdata;
                `OFF_ERR: err_next = err_reg & ~reg_req_i.wdata;
                default: clr = '0;
            endcase
        end
        run_next = run_next & ~(halt_reg & ~busy_mask);
        if (wb_en)
        begin
            clr[cur_ch_reg] = 1'b1;
            if (wb_blk || wb_err || wb_halt)
                run_next = run_next & ~clr;
            if (wb_blk)
                tfr_next = tfr_next | clr;
            if (wb_err)
                err_next = err_next | clr;
        end
        halt_next = halt_next & run_next;
        ivec_next = tfr_next | err_next;
        intr_next = |ivec_next;
        if (reg_req_i.rd)
        begin
            if (reg_req_i.addr < `CH_AREA_END)
            begin
                unique case (reg_req_i.addr[3:2])
                    `OFF_SRC: rdata_next = src_mem[reg_req_i.addr[8:4]];
                    `OFF_TGT: rdata_next = tgt_mem[reg_req_i.addr[8:4]];
                    `OFF_PCTL: rdata_next = pctl_mem[reg_req_i.addr[8:4]];
                    `OFF_SCTL: rdata_next = sctl_mem[reg_req_i.addr[8:4]];
                endcase
            end
            else
            begin
                unique case (reg_req_i.addr)
                    `OFF_RUN: rdata_next = run_reg;
                    `OFF_HALT: rdata_next = halt_reg;
                    `OFF_TFR: rdata_next = tfr_reg;
                    `OFF_ERR: rdata_next = err_reg;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                src_mem[c] <= `RST_WORD;
                tgt_mem[c] <= `RST_WORD;
                pctl_mem[c] <= `RST_WORD;
                sctl_mem[c] <= `RST_WORD;
            end
            for (int s = 0; s < 4; s++)
                rr_reg[s] <= 3'h7;
            run_reg <= '0;
            halt_reg <= '0;
            tfr_reg <= '0;
            err_reg <= '0;
            rdata_reg <= '0;
            intr_reg <= 1'b0;
            ivec_reg <= '0;
            state_reg <= ST_IDLE;
            cur_ch_reg <= '0;
            cur_src_reg <= '0;
            cur_tgt_reg <= '0;
            cur_len_reg <= '0;
            items_reg <= '0;
            data_reg <= '0;
            single_reg <= 1'b0;
            mas_reg <= '{haddr: 32'h0000_0000, htrans: `HTRANS_IDLE, hsize: 3'h0,
                hburst: `HBURST_SINGLE, hprot: `HPROT_DATA, hmastlock: 1'b0,
                hwrite: 1'b0, hwdata: 32'h0000_0000};
            ack_reg <= '0;
            done_reg <= '0;
            slot_reg <= '0;
        end
        else if (ce_i)
        begin
            if (reg_req_i.wr && reg_req_i.addr < `CH_AREA_END)
            begin
                unique case (reg_req_i.addr[3:2])
                    `OFF_SRC: src_mem[reg_req_i.addr[8:4]] <= reg_req_i.wdata;
                    `OFF_TGT: tgt_mem[reg_req_i.addr[8:4]] <= reg_req_i.wdata;
                    `OFF_PCTL: pctl_mem[reg_req_i.addr[8:4]] <= reg_req_i.wdata;
                    `OFF_SCTL: sctl_mem[reg_req_i.addr[8:4]] <= reg_req_i.wdata;
                endcase
            end
            if (wb_en)
            begin
                src_mem[cur_ch_reg] <= cur_src_next;
                tgt_mem[cur_ch_reg] <= cur_tgt_next;
                pctl_mem[cur_ch_reg][`F_LEN_HI:`F_LEN_LO] <= cur_len_next;
            end
            rr_reg <= rr_next;
            run_reg <= run_next;
            halt_reg <= halt_next;
            tfr_reg <= tfr_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
            intr_reg <= intr_next;
            ivec_reg <= ivec_next;
            state_reg <= state_next;
            cur_ch_reg <= cur_ch_next;
            cur_src_reg <= cur_src_next;
            cur_tgt_reg <= cur_tgt_next;
            cur_len_reg <= cur_len_next;
            items_reg <= items_next;
            data_reg <= data_next;
            single_reg <= single_next;
            mas_reg <= mas_next;
            ack_reg <= ack_next;
            done_reg <= done_next;
            slot_reg <= slot_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign mas_o = mas_reg;
    assign per_ack_o = ack_reg;
    assign per_done_o = done_reg;
    assign intr_any_o = intr_reg;
    assign intr_chan_o = ivec_reg;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);

    property p_ack_release;
        (state_reg == ST_ACK && !hs_cur) |=> per_ack_o == '0;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack not released");

    property p_ack_hold;
        (state_reg == ST_ACK && hs_cur) |=> per_ack_o[$past(cur_pn)];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");

    property p_done_clear;
        (wb_en && wb_blk) |=> !run_reg[$past(cur_ch_reg)] && tfr_reg[$past(cur_ch_reg)];
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("run kept after block");

    property p_no_enable_pending;
        1'b1 |=> (run_reg & ~$past(run_reg) & $past(tfr_reg | err_reg)) == '0;
    endproperty
    a_no_enable_pending: assert property (p_no_enable_pending) else $error("started pending");

    property p_halt_idle;
        1'b1 |=> ($past(halt_reg & ~busy_mask) & run_reg) == '0;
    endproperty
    a_halt_idle: assert property (p_halt_idle) else $error("idle halt ignored");

    property p_halt_autoclear;
        (halt_reg & ~run_reg) == '0;
    endproperty
    a_halt_autoclear: assert property (p_halt_autoclear) else $error("halt left set");

    property p_int_vec;
        intr_chan_o == (tfr_reg | err_reg) && intr_any_o == |intr_chan_o;
    endproperty
    a_int_vec: assert property (p_int_vec) else $error("interrupt outputs wrong");

    property p_slot;
        (state_reg == ST_IDLE && set_elig == 4'hF) |-> pick_set == slot_set(slot_reg);
    endproperty
    a_slot: assert property (p_slot) else $error("weighted slot skipped");

    property p_cv_ack;
        state_reg == ST_ACK ##1 state_reg == ST_IDLE;
    endproperty
    c_ack: cover property (p_cv_ack);

    property p_cv_block;
        wb_en && wb_blk;
    endproperty
    c_block: cover property (p_cv_block);

    property p_cv_err;
        wb_en && wb_err;
    endproperty
    c_err: cover property (p_cv_err);

endmodule

/* mem_slave_model.sv */
// Memory slave model for the engine's bus master port.
// Assumes single, non-pipelined transfers from one master.
`timescale 1ns/10ps
`include "dma_arb_map.svh"
module mem_slave_model
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire dma_arb_pkg::ahb_mst_t mas_i,
    output logic [31:0] hrdata_o,
    output logic hready_o
);
    import dma_arb_pkg::*;
    logic [31:0] mem [0:63];
    logic [5:0] addr_reg;
    logic rd_reg;
    logic wr_reg;
    logic wait_reg;
    logic [31:0] last_reg;
    // Stalls every other cycle when slow
    assign hready_o = !slow_i || wait_reg;
    // A released read bus shows the inverse of the last word
    assign hrdata_o = rd_reg ? mem[addr_reg] : ~last_reg;
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 32'hA5A5_0000 + i;
    end
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            wait_reg <= 1'b0;
            last_reg <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= !wait_reg;
            if (hready_o)
            begin
                if (wr_reg)
                    mem[addr_reg] <= mas_i.hwdata;
                if (rd_reg)
                    last_reg <= mem[addr_reg];
                rd_reg <= (mas_i.htrans == `HTRANS_NONSEQ) && !mas_i.hwrite;
                wr_reg <= (mas_i.htrans == `HTRANS_NONSEQ) && mas_i.hwrite;
                addr_reg <= mas_i.haddr[7:2];
            end
        end
    end
endmodule

/* test_dma_arb_core.sv */
// Self-checking bench for the transfer engine.
// Assumes mem_slave_model on the bus and a peripheral driven here.
`timescale 1ns/10ps
`include "dma_arb_map.svh"
module test_dma_arb_core;
    import dma_arb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic slow = 1'b0;
    reg_req_t req = '0;
    logic [31:0] rdata;
    ahb_mst_t mas;
    logic [31:0] hrdata;
    logic hready;
    logic [63:0] breq = '0;
    logic [63:0] ack;
    logic [63:0] done;
    logic intr_any;
    logic [31:0] intr_chan;
    logic [31:0] d;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    always #2 clk_sys_i = !clk_sys_i;
    dma_arb_core DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .reg_req_i(req), .reg_rdata_o(rdata), .mas_o(mas), .mas_hrdata_i(hrdata),
        .mas_hready_i(hready), .mas_hresp_i(1'b0), .per_burst_req_i(breq),
        .per_single_req_i(64'h0000_0000_0000_0000), .per_last_i(64'h0000_0000_0000_0000),
        .per_ack_o(ack), .per_done_o(done), .intr_any_o(intr_any), .intr_chan_o(intr_chan));
    mem_slave_model MEM (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .mas_i(mas), .hrdata_o(hrdata), .hready_o(hready));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
        // Gap edge so a following write never re-drives the strobe in this step
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        @(negedge clk_sys_i);
        v = rdata;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_idle(input logic [31:0] m);
        for (int i = 0; i < 100; i++)
        begin
            rd(`OFF_RUN, d);
            if ((d & m) === 32'h0000_0000)
                break;
        end
    endtask
    task automatic mem_copy();
        slow <= 1'b1;
        wr(12'h000, 32'h0000_0000);
        wr(12'h004, 32'h0000_0080);
        wr(12'h008, 32'h0019_0008);
        wr(`OFF_RUN, 32'h0000_0001);
        wait_idle(32'h0000_0001);
        check(d, 32'h0000_0000);
        check(MEM.mem[33], 32'hA5A5_0001);
        check({intr_any, intr_chan}, {1'b1, 32'h0000_0001});
        wr(`OFF_RUN, 32'h0000_0001);
        rd(`OFF_RUN, d);
        check(d, 32'h0000_0000);
        wr(`OFF_TFR, 32'h0000_0001);
        rd(`OFF_TFR, d);
        check({intr_any, d}, 33'h0_0000_0000);
        slow <= 1'b0;
    endtask
    task automatic per_burst();
        wr(12'h100, 32'h0000_0000);
        wr(12'h104, 32'h0000_00F0);
        wr(12'h108, 32'h0009_2010);
        wr(12'h10C, 32'h0000_0005);
        wr(`OFF_RUN, 32'h0001_0000);
        breq[5] <= 1'b1;
        for (int i = 0; i < 200 && ack[5] !== 1'b1; i++)
            @(posedge clk_sys_i);
        check({done[5], MEM.mem[60]}, {1'b1, 32'hA5A5_0003});
        breq[5] <= 1'b0;
        @(posedge clk_sys_i);
        check(ack[5], 1'b1);
        repeat (2) @(posedge clk_sys_i);
        check({ack[5], done[5]}, 2'b00);
    endtask
    task automatic weighted();
        for (int c = 0; c < 16; c += 4)
        begin
            wr(12'(c * 16), 32'(32'h0000_0010 + c));
            wr(12'(c * 16 + 4), 32'(32'h0000_00C0 + c));
            wr(12'(c * 16 + 8), 32'h0019_0004);
        end
        wr(`OFF_RUN, 32'h0000_1111);
        wait_idle(32'h0000_1111);
        check(d, 32'h0000_0000);
        for (int c = 0; c < 4; c++)
            check(MEM.mem[48 + c], 32'(32'hA5A5_0004 + c));
        check(intr_chan, 32'h0001_1111);
    endtask
    task automatic halt_idle();
        wr(12'h018, 32'h0000_4004);
        wr(12'h01C, 32'h0000_0006);
        wr(`OFF_RUN, 32'h0000_0002);
        wr(`OFF_HALT, 32'h0000_0002);
        wait_idle(32'h0000_0002);
        check(d, 32'h0000_0000);
        rd(`OFF_HALT, d);
        check(d, 32'h0000_0000);
        wr(`OFF_HALT, 32'h0000_0000);
        rd(`OFF_RUN, d);
        check(d, 32'h0000_0000);
        rd(12'h300, d);
        check(d, 32'h0000_0000);
    endtask
    task automatic final_report();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        check({intr_any, mas.hprot, rdata}, {1'b0, 4'h3, 32'h0000_0000});
        mem_copy();
        per_burst();
        weighted();
        halt_idle();
        final_report();
    end
endmodule
